/* rtl/iabu_core.sv */
/*
  Interrupt and storage-bounds unit: condition, select and product words,
  Category I entry with lockout, immediate Category II and III traps,
  and eight-bit upper and lower storage limits.
  Assumes the instruction sequencer on the same clock drives the boundary,
  decode, access, fetch and internal-function ports; only channel request
  lines come from outside this clock and are synchronised here.
*/
`timescale 1ns/1ps

// Operation
// - Limit-load instructions each place an 8-bit value in their limit register.
// - An all-ones limit compares as address 77600 octal.
// - Checking needs system active and select bit 42, set in any order.
// - Out-of-range jump is suppressed, raises Category I, resumes at next instruction.
// - Out-of-range write or fetch raises Category I; operand reads always allowed.
// - Address bits 7-14 in range when at least lower and below upper.
// - An all-zero upper limit is ignored; only the lower limit applies.
// - Global clear leaves limits alone; software clears them by loading zeros.
// - Limit loads while checking trap as Category III and change nothing.
// - Checking is off while any Category I, II or III mode latch is set.
// - Conditions sampled after each instruction; a pending one halts and saves P.
// - Internal function activates, deactivates, and sets or clears condition and select bits.
// - The three words are numbered 0 right to 47 left, same meaning per bit.
// - Internal conditions drive fixed bits; channel request lines drive external bits.
// - Product word is the plain AND of condition and select words.
// - Category II and III traps are taken at once, regardless of activation.
// - Listed illegal codes, some only in certain variants, trap as Category III.
// - Category I taken when selected, system active and mode latch clear; jumps to 00007.
// - Category I entry stops at the end of an instruction or search iteration.
// - Entry sets lockout, sets mode latch, return-jumps, then clears lockout.
// - Lower next stores P with lower exit; upper next stores P+1 with upper exit.
// - When P reaches the vector again, use the stored exit and clear the mode latch.
// - A write or fetch bounds-fault Category I re-executes the faulting step after service.
// - Bits 20-23 parity, 30-33 external, 10-13 inactive for channels 0-3.
// - Category II return-jumps to the address equal to its opcode, 00030-00033.
module iabu_core
  import iabu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Option strap
  input wire logic float_arith_option,
  // Sequencer requests
  input iabu_pkg::iabu_boundary_t boundary,
  input iabu_pkg::iabu_decode_t decode,
  input iabu_pkg::iabu_ifn_t ifn,
  input iabu_pkg::iabu_access_t access,
  input iabu_pkg::iabu_fetch_t fetch,
  // Condition sources
  input wire logic [47:0] int_cond,
  input iabu_pkg::iabu_chan_t chan_req,
  // Answers to the sequencer
  output logic access_block,
  output iabu_pkg::iabu_trap_t trap,
  output iabu_pkg::iabu_ret_t ret,
  // Visible state
  output logic [47:0] pending_condition_register,
  output logic [47:0] condition_select_register,
  output logic [47:0] qualified_request_vector,
  output logic [7:0] upper_storage_limit,
  output logic [7:0] lower_storage_limit,
  output logic system_active,
  output logic [2:0] mode_latch,
  output logic cat1_lockout
);
  import iabu_pkg::*;

  typedef struct packed {
    iabu_fsm_t fsm;
    logic active;
    logic lockout;
    logic mode1;
    logic mode2;
    logic mode3;
    logic exit1;
    logic exit2;
    logic exit3;
    logic redo;
    logic [14:0] redo_step;
    logic [47:0] cond;
    logic [47:0] sel;
    logic [7:0] ulim;
    logic [7:0] llim;
    iabu_chan_t sync1;
    iabu_chan_t sync2;
    iabu_trap_t trap;
    iabu_ret_t ret;
  } iabu_core_state_t;

  iabu_core_state_t state_q;
  iabu_core_state_t state_d;

  logic [47:0] product;
  logic [47:0] chan_vec;
  logic checking;
  logic out_of_range;
  logic fault_jump;
  logic fault_store;
  logic cat2_hit;
  logic cat3_hit;
  logic cat1_due;
  logic limit_load;

  // A limit as a 15-bit address boundary; all ones stands for a fixed address.
  function automatic logic [14:0] iabu_lim_addr(input logic [7:0] lim);
    logic [14:0] a;
    a = {lim, 7'h00};
    if (lim == IABU_LIM_ONES)
    begin
      a = IABU_LIM_ONES_ADDR;
    end
    return a;
  endfunction : iabu_lim_addr

  // Range test on address bits 7 through 14 only.
  function automatic logic iabu_in_range(input logic [14:0] addr, input logic [7:0] ulim,
                                         input logic [7:0] llim);
    logic [14:0] s;
    logic ok;
    s = {addr[14:IABU_LIM_LSB], 7'h00};
    ok = (s >= iabu_lim_addr(llim));
    if (ulim != IABU_LIM_ZERO)
    begin
      ok = ok && (s < iabu_lim_addr(ulim));
    end
    return ok;
  endfunction : iabu_in_range

  // Illegal operation decode; the sequencer flags the bad variants of starred codes.
  function automatic logic iabu_illegal(input iabu_decode_t d, input logic chk);
    logic bad;
    bad = 1'b0;
    case (d.op)
      IABU_OP_00, IABU_OP_63:
      begin
        bad = d.variant_bad;
      end
      IABU_OP_26, IABU_OP_27, IABU_OP_62:
      begin
        bad = 1'b1;
      end
      IABU_OP_74:
      begin
        bad = (d.sub == IABU_SUB_7) || d.variant_bad;
      end
      IABU_OP_77:
      begin
        if ((d.sub == IABU_SUB_0) || (d.sub == IABU_SUB_7))
        begin
          bad = 1'b1;
        end
        else if ((d.sub == IABU_SUB_UPPER_LIM) || (d.sub == IABU_SUB_LOWER_LIM))
        begin
          bad = chk;
        end
      end
      default:
      begin
        bad = 1'b0;
      end
    endcase
    return bad;
  endfunction : iabu_illegal

  // Channel request lines placed at their fixed positions.
  always_comb
  begin
    chan_vec = '0;
    for (int i = 0; i < IABU_CH; i++)
    begin
      chan_vec[IABU_BIT_PAR + i] = state_q.sync2.parity[i];
      chan_vec[IABU_BIT_EXT + i] = state_q.sync2.ext[i];
      chan_vec[IABU_BIT_INACT + i] = state_q.sync2.inactive[i];
    end
  end

  always_comb
  begin
    product = state_q.cond & state_q.sel;
    checking = state_q.active && state_q.sel[IABU_BIT_OOB]
               && !(state_q.mode1 || state_q.mode2 || state_q.mode3);
    out_of_range = !iabu_in_range(access.addr, state_q.ulim, state_q.llim);
    fault_jump = checking && out_of_range && (access.kind == IABU_ACC_JUMP);
    fault_store = checking && out_of_range
                  && ((access.kind == IABU_ACC_WRITE) || (access.kind == IABU_ACC_FETCH));
    cat2_hit = decode.valid && !float_arith_option
               && (decode.op >= IABU_OP_FLT_LO) && (decode.op <= IABU_OP_FLT_HI);
    cat3_hit = decode.valid && !cat2_hit && iabu_illegal(decode, checking);
    limit_load = decode.valid && !cat3_hit && (decode.op == IABU_OP_77)
                 && ((decode.sub == IABU_SUB_UPPER_LIM) || (decode.sub == IABU_SUB_LOWER_LIM));
    cat1_due = boundary.valid && (|product) && state_q.active && !state_q.mode1
               && !state_q.lockout && (state_q.fsm == IABU_ST_IDLE);
  end

  always_comb
  begin
    state_d = state_q;
    state_d.trap.take = 1'b0;
    state_d.ret.valid = 1'b0;

    // Channel lines come from another domain and pass two flip-flops first.
    state_d.sync1 = chan_req;
    state_d.sync2 = state_q.sync1;

    // Hardware sets win over a software clear in the same cycle.
    if (ifn.valid)
    begin
      case (ifn.code)
        IABU_IFN_ACTIVATE:
        begin
          state_d.active = 1'b1;
        end
        IABU_IFN_DEACTIVATE:
        begin
          state_d.active = 1'b0;
        end
        IABU_IFN_SET_COND:
        begin
          state_d.cond[ifn.bit_idx] = 1'b1;
        end
        IABU_IFN_CLR_COND:
        begin
          state_d.cond[ifn.bit_idx] = 1'b0;
        end
        IABU_IFN_SET_SEL:
        begin
          state_d.sel[ifn.bit_idx] = 1'b1;
        end
        IABU_IFN_CLR_SEL:
        begin
          state_d.sel[ifn.bit_idx] = 1'b0;
        end
        default:
        begin
          state_d.active = state_q.active;
        end
      endcase
    end
    state_d.cond = state_d.cond | int_cond | chan_vec;
    if (fault_jump || fault_store)
    begin
      state_d.cond[IABU_BIT_OOB] = 1'b1;
    end
    if (fault_store)
    begin
      state_d.redo = 1'b1;
      state_d.redo_step = boundary.step;
    end

    // Limits change only through a legal load instruction.
    if (limit_load)
    begin
      if (decode.sub == IABU_SUB_UPPER_LIM)
      begin
        state_d.ulim = decode.operand;
      end
      else
      begin
        state_d.llim = decode.operand;
      end
    end

    // Returns: the fetch of a vector address releases its mode latch.
    if (fetch.valid)
    begin
      if ((fetch.p == IABU_VEC_CAT1) && state_q.mode1)
      begin
        state_d.mode1 = 1'b0;
        state_d.ret = '{valid: 1'b1, category: IABU_CAT_1, exit_lower: state_q.exit1};
      end
      else if ((fetch.p == IABU_VEC_CAT3) && state_q.mode3)
      begin
        state_d.mode3 = 1'b0;
        state_d.ret = '{valid: 1'b1, category: IABU_CAT_3, exit_lower: state_q.exit3};
      end
      else if ((fetch.p >= {9'h000, IABU_OP_FLT_LO}) && (fetch.p <= {9'h000, IABU_OP_FLT_HI})
               && state_q.mode2)
      begin
        state_d.mode2 = 1'b0;
        state_d.ret = '{valid: 1'b1, category: IABU_CAT_2, exit_lower: state_q.exit2};
      end
    end

    // Traps are immediate and take priority over a Category I entry.
    if (cat2_hit)
    begin
      state_d.mode2 = 1'b1;
      state_d.exit2 = decode.is_lower;
      state_d.trap = '{take: 1'b1, category: IABU_CAT_2, vector: {9'h000, decode.op},
                       store_addr: decode.p, exit_lower: decode.is_lower};
    end
    else if (cat3_hit)
    begin
      state_d.mode3 = 1'b1;
      state_d.exit3 = decode.is_lower;
      state_d.trap = '{take: 1'b1, category: IABU_CAT_3, vector: IABU_VEC_CAT3,
                       store_addr: decode.p, exit_lower: decode.is_lower};
    end

    case (state_q.fsm)
      IABU_ST_IDLE:
      begin
        if (cat1_due && !cat2_hit && !cat3_hit)
        begin
          state_d.fsm = IABU_ST_ENTER;
          state_d.lockout = 1'b1;
          state_d.mode1 = 1'b1;
          state_d.trap.take = 1'b1;
          state_d.trap.category = IABU_CAT_1;
          state_d.trap.vector = IABU_VEC_CAT1;
          if (state_q.redo)
          begin
            state_d.exit1 = 1'b0;
            state_d.redo = fault_store;
            state_d.trap.store_addr = state_q.redo_step;
            state_d.trap.exit_lower = 1'b0;
          end
          else if (boundary.next_lower)
          begin
            state_d.exit1 = 1'b1;
            state_d.trap.store_addr = boundary.p;
            state_d.trap.exit_lower = 1'b1;
          end
          else
          begin
            state_d.exit1 = 1'b0;
            state_d.trap.store_addr = boundary.p + IABU_ONE_ADDR;
            state_d.trap.exit_lower = 1'b0;
          end
        end
      end
      IABU_ST_ENTER:
      begin
        state_d.fsm = IABU_ST_RELEASE;
      end
      IABU_ST_RELEASE:
      begin
        state_d.lockout = 1'b0;
        state_d.fsm = IABU_ST_IDLE;
      end
      default:
      begin
        state_d.lockout = 1'b0;
        state_d.fsm = IABU_ST_IDLE;
      end
    endcase

    // Global clear resets control state but deliberately keeps both limits.
    if (rst)
    begin
      state_d = '0;
      state_d.fsm = IABU_ST_IDLE;
      state_d.ulim = state_q.ulim;
      state_d.llim = state_q.llim;
    end
  end

  always_ff @(posedge clock)
  begin
    state_q <= state_d;
  end

  // A suppressed jump must never be executed, so the block answer is combinational.
  assign access_block = fault_jump;
  assign trap = state_q.trap;
  assign ret = state_q.ret;
  assign pending_condition_register = state_q.cond;
  assign condition_select_register = state_q.sel;
  assign qualified_request_vector = product;
  assign upper_storage_limit = state_q.ulim;
  assign lower_storage_limit = state_q.llim;
  assign system_active = state_q.active;
  assign mode_latch = {state_q.mode3, state_q.mode2, state_q.mode1};
  assign cat1_lockout = state_q.lockout;

endmodule : iabu_core

/* rtl/iabu_pkg.sv */
/*
  Shared types and constants of the interrupt and bounds unit: bit positions,
  fixed vector addresses, opcodes and the structs carried on its ports.
  Assumes a 15-bit storage address and a 48-bit condition word.
*/
package iabu_pkg;

  localparam int IABU_W = 48;
  localparam int IABU_AW = 15;
  localparam int IABU_LW = 8;
  localparam int IABU_CH = 4;

  // Fixed return-jump targets and the all-ones limit substitute.
  localparam logic [14:0] IABU_VEC_CAT1 = 15'h0007;
  localparam logic [14:0] IABU_VEC_CAT3 = 15'h0010;
  localparam logic [14:0] IABU_LIM_ONES_ADDR = 15'h7f80;
  localparam logic [7:0] IABU_LIM_ONES = 8'hff;
  localparam logic [7:0] IABU_LIM_ZERO = 8'h00;
  localparam logic [14:0] IABU_ONE_ADDR = 15'h0001;
  localparam int IABU_LIM_LSB = 7;

  // Condition bit positions.
  localparam int IABU_BIT_OOB = 42;
  localparam int IABU_BIT_INACT = 10;
  localparam int IABU_BIT_PAR = 20;
  localparam int IABU_BIT_EXT = 30;

  // Operation codes and sub-codes.
  localparam logic [5:0] IABU_OP_00 = 6'h00;
  localparam logic [5:0] IABU_OP_26 = 6'h16;
  localparam logic [5:0] IABU_OP_27 = 6'h17;
  localparam logic [5:0] IABU_OP_FLT_LO = 6'h18;
  localparam logic [5:0] IABU_OP_FLT_HI = 6'h1b;
  localparam logic [5:0] IABU_OP_62 = 6'h32;
  localparam logic [5:0] IABU_OP_63 = 6'h33;
  localparam logic [5:0] IABU_OP_74 = 6'h3c;
  localparam logic [5:0] IABU_OP_77 = 6'h3f;
  localparam logic [2:0] IABU_SUB_0 = 3'h0;
  localparam logic [2:0] IABU_SUB_UPPER_LIM = 3'h5;
  localparam logic [2:0] IABU_SUB_LOWER_LIM = 3'h6;
  localparam logic [2:0] IABU_SUB_7 = 3'h7;

  typedef enum logic [1:0] {
    IABU_CAT_NONE = 2'b00,
    IABU_CAT_1 = 2'b01,
    IABU_CAT_2 = 2'b10,
    IABU_CAT_3 = 2'b11
  } iabu_cat_t;

  typedef enum logic [2:0] {
    IABU_ACC_NONE = 3'b000,
    IABU_ACC_JUMP = 3'b001,
    IABU_ACC_WRITE = 3'b010,
    IABU_ACC_FETCH = 3'b011,
    IABU_ACC_OPERAND = 3'b100
  } iabu_acc_t;

  typedef enum logic [2:0] {
    IABU_IFN_ACTIVATE = 3'b000,
    IABU_IFN_DEACTIVATE = 3'b001,
    IABU_IFN_SET_COND = 3'b010,
    IABU_IFN_CLR_COND = 3'b011,
    IABU_IFN_SET_SEL = 3'b100,
    IABU_IFN_CLR_SEL = 3'b101
  } iabu_ifn_code_t;

  typedef enum logic [1:0] {
    IABU_ST_IDLE = 2'b00,
    IABU_ST_ENTER = 2'b01,
    IABU_ST_RELEASE = 2'b10
  } iabu_fsm_t;

  typedef struct packed {
    logic valid;
    logic next_lower;
    logic [14:0] p;
    logic [14:0] step;
  } iabu_boundary_t;

  typedef struct packed {
    logic valid;
    logic [5:0] op;
    logic [2:0] sub;
    logic variant_bad;
    logic is_lower;
    logic [14:0] p;
    logic [7:0] operand;
  } iabu_decode_t;

  typedef struct packed {
    logic valid;
    iabu_ifn_code_t code;
    logic [5:0] bit_idx;
  } iabu_ifn_t;

  typedef struct packed {
    iabu_acc_t kind;
    logic [14:0] addr;
  } iabu_access_t;

  typedef struct packed {
    logic valid;
    logic [14:0] p;
  } iabu_fetch_t;

  typedef struct packed {
    logic [3:0] parity;
    logic [3:0] ext;
    logic [3:0] inactive;
  } iabu_chan_t;

  typedef struct packed {
    logic take;
    iabu_cat_t category;
    logic [14:0] vector;
    logic [14:0] store_addr;
    logic exit_lower;
  } iabu_trap_t;

  typedef struct packed {
    logic valid;
    iabu_cat_t category;
    logic exit_lower;
  } iabu_ret_t;

endpackage : iabu_pkg

/* verif/iabu_chan_model.sv */
/*
  Behavioural model of the data channels' request lines.
  Assumes the bench asks for a line pattern by a one-cycle raise pulse.
*/
`timescale 1ns/1ps
module iabu_chan_model
  import iabu_pkg::*;
(
  // Clock
  input wire logic clock,
  // Requested pattern {parity, ext, inactive}
  input wire logic [11:0] raise,
  // Channel lines
  output iabu_pkg::iabu_chan_t chan_req
);
  logic [11:0] lines;
  int hold;
  assign chan_req = lines;
  initial
  begin
    lines = 12'h000;
    hold = 0;
    forever
    begin
      @(posedge clock);
      if (|raise && hold == 0)
      begin
        // Lines move off the core edge, as a channel in its own timing would.
        #7;
        lines = raise;
        hold = 3 + ($urandom % 4);
      end
      else if (hold != 0)
      begin
        hold--;
        if (hold == 0)
          lines = 12'h000;
      end
    end
  end
endmodule : iabu_chan_model

/* verif/iabu_core_properties.sv */
/*
  Concurrent checks on the ports of the interrupt and bounds unit.
  Assumes the single clock and synchronous active-high reset of the core.
*/
`timescale 1ns/1ps
module iabu_core_properties
  import iabu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Core inputs
  input wire logic float_arith_option,
  input iabu_pkg::iabu_boundary_t boundary,
  input iabu_pkg::iabu_decode_t decode,
  input iabu_pkg::iabu_ifn_t ifn,
  input iabu_pkg::iabu_access_t access,
  input iabu_pkg::iabu_fetch_t fetch,
  input wire logic [47:0] int_cond,
  input iabu_pkg::iabu_chan_t chan_req,
  // Core outputs
  input wire logic access_block,
  input iabu_pkg::iabu_trap_t trap,
  input iabu_pkg::iabu_ret_t ret,
  input wire logic [47:0] pending_condition_register,
  input wire logic [47:0] condition_select_register,
  input wire logic [47:0] qualified_request_vector,
  input wire logic [7:0] upper_storage_limit,
  input wire logic [7:0] lower_storage_limit,
  input wire logic system_active,
  input wire logic [2:0] mode_latch,
  input wire logic cat1_lockout
);
  logic chk;
  logic lim_ld;
  logic out_rng;
  logic flt;
  assign chk = system_active & condition_select_register[IABU_BIT_OOB] & (mode_latch == 3'h0);
  assign lim_ld = decode.valid & (decode.op == IABU_OP_77)
    & (decode.sub == IABU_SUB_UPPER_LIM | decode.sub == IABU_SUB_LOWER_LIM);
  // Comparing the top eight bits is enough: an all-ones limit shifted up is already 77600 octal.
  assign out_rng = (access.addr[14:7] < lower_storage_limit)
    | ((upper_storage_limit != 8'h00) & (access.addr[14:7] >= upper_storage_limit));
  assign flt = decode.valid & (decode.op >= IABU_OP_FLT_LO) & (decode.op <= IABU_OP_FLT_HI);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_product_and:
    assert property (qualified_request_vector == (pending_condition_register & condition_select_register))
    else $error("product word mismatch");
  a_limit_load:
    assert property (lim_ld && !chk && decode.sub == IABU_SUB_UPPER_LIM
      |=> upper_storage_limit == $past(decode.operand))
    else $error("upper limit not loaded");
  a_load_refused:
    assert property (lim_ld && chk |=> trap.take && trap.category == IABU_CAT_3
      && $stable(upper_storage_limit) && $stable(lower_storage_limit))
    else $error("limit load while checking not refused");
  a_jump_block:
    assert property (access_block == (access.kind == IABU_ACC_JUMP && chk && out_rng))
    else $error("jump block mismatch");
  a_fault_flag:
    assert property ((access.kind == IABU_ACC_WRITE || access.kind == IABU_ACC_FETCH) && chk && out_rng
      |=> pending_condition_register[IABU_BIT_OOB])
    else $error("bounds fault not flagged");
  a_float_trap:
    assert property (flt && !float_arith_option |=> trap.take && trap.category == IABU_CAT_2
      && trap.vector == {9'h000, $past(decode.op)})
    else $error("float trap wrong");
  a_cat1_entry:
    assert property (boundary.valid && |qualified_request_vector && system_active && !mode_latch[0]
      && !cat1_lockout && !decode.valid
      |=> trap.take && trap.category == IABU_CAT_1 && trap.vector == IABU_VEC_CAT1 && mode_latch[0])
    else $error("entry not taken");
  a_lockout_span:
    assert property ($rose(cat1_lockout) |-> trap.take ##1 cat1_lockout ##1 !cat1_lockout)
    else $error("lockout span wrong");
  a_cat1_return:
    assert property (fetch.valid && fetch.p == IABU_VEC_CAT1 && mode_latch[0]
      |=> ret.valid && ret.category == IABU_CAT_1 && !mode_latch[0])
    else $error("return not signalled");
  a_cond_sticky:
    assert property (!(ifn.valid && ifn.code == IABU_IFN_CLR_COND) |=> (pending_condition_register
      & $past(pending_condition_register)) == $past(pending_condition_register))
    else $error("condition bit lost");
endmodule : iabu_core_properties

bind iabu_core iabu_core_properties i_props (.clock, .rst, .float_arith_option, .boundary, .decode, .ifn,
  .access, .fetch, .int_cond, .chan_req, .access_block, .trap, .ret, .pending_condition_register,
  .condition_select_register, .qualified_request_vector, .upper_storage_limit, .lower_storage_limit,
  .system_active, .mode_latch, .cat1_lockout);

/* verif/tb.sv */
/*
  Self-checking bench of the interrupt and bounds unit.
  Assumes the core and the channel model; inputs change on the falling edge.
*/
`timescale 1ns/1ps
module tb;
  import iabu_pkg::*;
  logic clock, rst, float_arith_option, access_block, system_active, cat1_lockout, nl;
  logic live = 1'h1;
  iabu_boundary_t boundary;
  iabu_decode_t decode;
  iabu_ifn_t ifn;
  iabu_access_t access;
  iabu_fetch_t fetch;
  iabu_chan_t chan_req;
  iabu_trap_t trap;
  iabu_ret_t ret;
  logic [47:0] int_cond, pending_condition_register, condition_select_register, qualified_request_vector, ep, es;
  logic [7:0] upper_storage_limit, lower_storage_limit, cu, cl;
  logic [2:0] mode_latch;
  logic [11:0] raise;
  logic [14:0] p;
  int bad_count, checks_done, b, k;
  logic [7:0] tu [6] = '{8'h05, 8'h05, 8'h05, 8'h00, 8'hff, 8'hff};
  logic [14:0] ta [6] = '{15'h0100, 15'h00ff, 15'h0280, 15'h7fff, 15'h7f7f, 15'h7f80};
  logic [5:0] top [9] = '{6'h00, 6'h16, 6'h17, 6'h32, 6'h33, 6'h3c, 6'h3c, 6'h3f, 6'h3f};
  logic [2:0] tsub [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h3, 3'h0, 3'h7};
  logic [8:0] tvb = 9'h051;

  iabu_core i_dut (.clock, .rst, .float_arith_option, .boundary, .decode, .ifn, .access, .fetch, .int_cond,
    .chan_req, .access_block, .trap, .ret, .pending_condition_register, .condition_select_register,
    .qualified_request_vector, .upper_storage_limit, .lower_storage_limit, .system_active, .mode_latch,
    .cat1_lockout);
  iabu_chan_model i_chan (.clock(clock), .raise(raise), .chan_req(chan_req));

  initial
  begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic oob(input logic [14:0] a);
    return a[14:7] < cl || (cu != 8'h00 && a[14:7] >= cu);
  endfunction : oob

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic dec(input logic [5:0] op, input logic [2:0] sub, input logic vb, input logic [7:0] v);
    @(negedge clock);
    decode = '{1'h1, op, sub, vb, 1'h1, 15'h0200, v};
    @(negedge clock);
    decode.valid = 1'h0;
  endtask : dec

  task automatic fn(input iabu_ifn_code_t c, input int n);
    @(negedge clock);
    ifn = '{1'h1, c, 6'(n)};
    @(negedge clock);
    ifn.valid = 1'h0;
  endtask : fn

  task automatic bnd(input logic n, input logic [14:0] a);
    @(negedge clock);
    boundary.valid = 1'h1;
    boundary.next_lower = n;
    boundary.p = a;
    @(negedge clock);
    boundary.valid = 1'h0;
  endtask : bnd

  task automatic back(input logic [14:0] a);
    @(negedge clock);
    fetch = '{1'h1, a};
    @(negedge clock);
    fetch.valid = 1'h0;
  endtask : back

  task automatic go(input iabu_acc_t t, input logic [14:0] a);
    @(negedge clock);
    access = '{t, a};
    #1;
    check(access_block, t == IABU_ACC_JUMP && live && oob(a));
    @(negedge clock);
    access.kind = IABU_ACC_NONE;
  endtask : go

  task automatic clear;
    @(negedge clock);
    rst = 1'h1;
    @(negedge clock);
    rst = 1'h0;
  endtask : clear

  // Loading traps while checking is on, so it is bracketed by deactivate and activate.
  task automatic limits(input logic [7:0] u, input logic [7:0] l);
    fn(IABU_IFN_DEACTIVATE, 0);
    cu = u;
    cl = l;
    dec(IABU_OP_77, IABU_SUB_UPPER_LIM, 1'h0, u);
    dec(IABU_OP_77, IABU_SUB_LOWER_LIM, 1'h0, l);
    fn(IABU_IFN_ACTIVATE, 0);
  endtask : limits

  initial
  begin
    repeat (30000) @(posedge clock);
    bad_count++;
    complete_run;
  end

  initial
  begin
    void'($urandom(32'h80e9));
    {boundary, decode, ifn, access, fetch, int_cond, raise} = '0;
    float_arith_option = 1'h1;
    rst = 1'h1;
    bad_count = 0;
    checks_done = 0;
    repeat (10) @(negedge clock);
    rst = 1'h0;
    check(pending_condition_register | condition_select_register, 48'h0);
    check({system_active, mode_latch, cat1_lockout}, 5'h00);
    limits(8'($urandom_range(1, 254)), 8'($urandom_range(0, 255)));
    check({upper_storage_limit, lower_storage_limit, system_active}, {cu, cl, 1'h1});
    clear;
    check({upper_storage_limit, lower_storage_limit}, {cu, cl});
    limits(8'h00, 8'h00);
    check({upper_storage_limit, lower_storage_limit}, 16'h0000);
    clear;
    ep = '0;
    es = '0;
    repeat (16)
    begin
      b = $urandom_range(0, 47);
      k = $urandom_range(2, 5);
      fn(iabu_ifn_code_t'(k), b);
      if (k < 4)
        ep[b] = (k == 2);
      else
        es[b] = (k == 4);
      check(pending_condition_register, ep);
      check(qualified_request_vector, ep & es);
    end
    check(condition_select_register, es);
    clear;
    ep = 48'({$urandom, $urandom});
    int_cond = ep;
    @(negedge clock);
    int_cond = '0;
    repeat (4) @(negedge clock);
    check(pending_condition_register, ep);
    clear;
    k = $urandom_range(1, 4095);
    raise = 12'(k);
    @(negedge clock);
    raise = '0;
    repeat (12) @(negedge clock);
    ep = '0;
    ep[23:20] = k[11:8];
    ep[33:30] = k[7:4];
    ep[13:10] = k[3:0];
    check(pending_condition_register, ep);
    clear;
    fn(IABU_IFN_SET_SEL, IABU_BIT_OOB);
    for (int i = 0; i < 6; i++)
    begin
      limits(tu[i], 8'h02);
      go(IABU_ACC_OPERAND, ta[i]);
      check(pending_condition_register[42], 1'h0);
      go(IABU_ACC_JUMP, ta[i]);
      fn(IABU_IFN_CLR_COND, 42);
      go(IABU_ACC_WRITE, ta[i]);
      check(pending_condition_register[42], oob(ta[i]));
      fn(IABU_IFN_CLR_COND, 42);
    end
    dec(IABU_OP_77, IABU_SUB_LOWER_LIM, 1'h0, 8'h33);
    check({trap.take, trap.category, trap.vector, lower_storage_limit}, {1'h1, IABU_CAT_3, IABU_VEC_CAT3, cl});
    back(IABU_VEC_CAT3);
    clear;
    limits(8'h00, 8'h00);
    fn(IABU_IFN_SET_SEL, 3);
    fn(IABU_IFN_SET_COND, 3);
    for (int i = 0; i < 2; i++)
    begin
      nl = i[0];
      p = 15'($urandom_range(32, 30000));
      bnd(nl, p);
      check({trap.take, trap.category, trap.vector, trap.store_addr, trap.exit_lower},
        {1'h1, IABU_CAT_1, IABU_VEC_CAT1, nl ? p : p + 15'h0001, nl});
      check({mode_latch[0], cat1_lockout}, 2'h3);
      bnd(nl, p);
      check(trap.take, 1'h0);
      back(IABU_VEC_CAT1);
      check({ret.valid, ret.category, ret.exit_lower, mode_latch[0]}, {1'h1, IABU_CAT_1, nl, 1'h0});
    end
    fn(IABU_IFN_CLR_SEL, 3);
    limits(8'h04, 8'h02);
    fn(IABU_IFN_SET_SEL, IABU_BIT_OOB);
    boundary.step = 15'h0123;
    go(IABU_ACC_FETCH, 15'h0000);
    bnd(1'h1, 15'h0300);
    check({trap.take, trap.store_addr, trap.exit_lower}, {1'h1, 15'h0123, 1'h0});
    live = 1'h0;
    go(IABU_ACC_JUMP, 15'h0000);
    back(IABU_VEC_CAT1);
    clear;
    float_arith_option = 1'h0;
    dec(6'h19, IABU_SUB_0, 1'h0, 8'h00);
    check({trap.take, trap.category, trap.vector, trap.store_addr, trap.exit_lower},
      {1'h1, IABU_CAT_2, 15'h0019, 15'h0200, 1'h1});
    back(15'h0019);
    check({ret.valid, ret.category, mode_latch[1]}, {1'h1, IABU_CAT_2, 1'h0});
    float_arith_option = 1'h1;
    dec(6'h19, IABU_SUB_0, 1'h0, 8'h00);
    check(trap.take, 1'h0);
    dec(IABU_OP_00, IABU_SUB_0, 1'h0, 8'h00);
    check(trap.take, 1'h0);
    for (int i = 0; i < 9; i++)
    begin
      dec(top[i], tsub[i], tvb[i], 8'h00);
      check({trap.take, trap.category, trap.vector}, {1'h1, IABU_CAT_3, IABU_VEC_CAT3});
      back(IABU_VEC_CAT3);
      check({ret.valid, ret.category, ret.exit_lower, mode_latch[2]}, {1'h1, IABU_CAT_3, 1'h1, 1'h0});
    end
    complete_run;
  end
endmodule : tb
